// *** dual_mode_transmit_only_streamer.sv ***
// Transmit-only streamer of a 128-byte serial memory with switch to two-wire mode.
`include "streamer_map.svh"
`default_nettype none
module dual_mode_transmit_only_streamer #(
   parameter int DEPTH = 128,
   parameter logic [127:0][7:0] INIT_ARRAY = '0
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_vclk,
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic i_mem_we,
   input wire logic [6:0] i_mem_addr,
   input wire logic [7:0] i_mem_wdata,
   output logic o_sda_out,
   output logic o_sda_oe,
   output logic [1:0] o_mode,
   output logic o_bidir,
   output logic o_write_enable
);
   if (DEPTH != 128) begin : g_depth_check
      $error("Depth must be 128 for a seven-bit pointer");
   end

   // ----------------------------------------
   // Elaboration checks
   // ----------------------------------------
   // The slot counter and the pointer are sized for these values only.
   if (`STREAM_SLOT_BITS != `STREAM_NULL_SLOT + 4'h1) begin : g_slot_check
      $error("The null bit must be the last bit of a slot");
   end
   if (`STREAM_LAST_ADDR != 7'(DEPTH - 1)) begin : g_last_check
      $error("The last address must be the top of the array");
   end
   if (`STREAM_SYNC_CLOCKS == 4'h0) begin : g_sync_check
      $error("At least one synchronisation clock is needed");
   end
   if (`STREAM_REVERT_PULSES == 8'h00) begin : g_revert_check
      $error("The fall-back count must not be zero");
   end

   typedef struct packed {
      streamer_pkg::mode_t mode;
      logic [3:0] sync_cnt;
      logic [3:0] bit_cnt;
      logic [6:0] ptr;
      logic [7:0] revert_cnt;
      logic [3:0] rx_cnt;
      logic [7:0] rx_shift;
      streamer_pkg::sda_drive_t sda;
   } state_t;

   state_t s_q;
   state_t s_d;
   logic [7:0] mem_q [DEPTH];
   streamer_pkg::pin_events_t ev;
   logic vclk_level;
   logic [7:0] cur_byte;
   logic [7:0] first_byte;

   // ----------------------------------------
   // Pin sampling
   // ----------------------------------------
   pin_sync u_pin_sync (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_vclk(i_vclk),
      .i_scl(i_scl),
      .i_sda(i_sda),
      .o_events(ev),
      .o_vclk_level(vclk_level)
   );

   // ----------------------------------------
   // Array storage
   // ----------------------------------------
   // The array is loaded from a user port; two-wire writes are outside this block.
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= INIT_ARRAY[i];
         end
      end else if (i_mem_we) begin
         mem_q[i_mem_addr] <= i_mem_wdata;
      end
   end

   assign cur_byte = mem_q[s_q.ptr];
   assign first_byte = mem_q[`STREAM_START_ADDR];

   // ----------------------------------------
   // Helper functions
   // ----------------------------------------
   // Slot zero carries the top bit of the byte.
   function automatic logic bit_of(input logic [7:0] b, input logic [3:0] idx);
      bit_of = b[3'(4'h7 - idx)];
   endfunction

   // Open-drain: a one is sent by releasing the line, a zero by pulling it low.
   function automatic streamer_pkg::sda_drive_t drive_for(input logic value);
      streamer_pkg::sda_drive_t d;
      d.drive_low = !value;
      d.oe = !value;
      return d;
   endfunction

   function automatic streamer_pkg::sda_drive_t released();
      return drive_for(`STREAM_SDA_IDLE);
   endfunction

   // The wrap is written out so that the pointer never relies on overflow.
   function automatic logic [6:0] next_ptr(input logic [6:0] p);
      logic [6:0] n;
      if (p == `STREAM_LAST_ADDR) begin
         n = `STREAM_START_ADDR;
      end else begin
         n = p + 7'h01;
      end
      return n;
   endfunction

   // Only the seven address bits are compared; the read or write bit is free.
   function automatic logic ctrl_match(input logic [6:0] addr);
      return addr == `STREAM_CTRL_CODE;
   endfunction

   // Starts a byte at the pointer already held in s by driving its top bit.
   function automatic state_t start_stream(input state_t s, input logic [7:0] b);
      state_t n;
      n = s;
      n.mode = streamer_pkg::MODE_STREAM;
      n.bit_cnt = 4'h1;
      n.sda = drive_for(bit_of(b, 4'h0));
      return n;
   endfunction

   // A byte in flight is cut short: the shared line is released at once.
   function automatic state_t enter_transit(input state_t s);
      state_t n;
      n = s;
      n.mode = streamer_pkg::MODE_TRANSIT;
      n.sda = released();
      n.revert_cnt = 8'h00;
      n.rx_cnt = 4'h0;
      return n;
   endfunction

   // ----------------------------------------
   // Synchronisation after power-up
   // ----------------------------------------
   // Edges before the tenth are only counted; the line stays released.
   function automatic state_t step_sync(input state_t s,
                                        input streamer_pkg::pin_events_t e,
                                        input logic [7:0] b);
      state_t n;
      n = s;
      n.sda = released();
      if (e.scl_fall) begin
         n = enter_transit(s);
      end else if (e.vclk_rise) begin
         if (s.sync_cnt == `STREAM_SYNC_CLOCKS) begin
            // Tenth rising edge: first top bit of location zero.
            n = start_stream(s, b);
         end else begin
            n.sync_cnt = s.sync_cnt + 4'h1;
         end
      end
      return n;
   endfunction

   // ----------------------------------------
   // Streaming
   // ----------------------------------------
   // Nine slots per byte: eight data bits, then the null bit.
   function automatic state_t step_stream(input state_t s,
                                          input streamer_pkg::pin_events_t e,
                                          input logic [7:0] b);
      state_t n;
      n = s;
      if (e.scl_fall) begin
         n = enter_transit(s);
      end else if (e.vclk_rise) begin
         if (s.bit_cnt == `STREAM_NULL_SLOT) begin
            n.sda = released();
            n.bit_cnt = 4'h0;
            n.ptr = next_ptr(s.ptr);
         end else begin
            n.sda = drive_for(bit_of(b, s.bit_cnt));
            n.bit_cnt = s.bit_cnt + 4'h1;
         end
      end
      return n;
   endfunction

   // ----------------------------------------
   // Transition state
   // ----------------------------------------
   // Counts transmit clock pulses and listens for the control byte at once.
   function automatic state_t step_transit(input state_t s,
                                           input streamer_pkg::pin_events_t e,
                                           input logic [7:0] b0);
      state_t n;
      n = s;
      n.sda = released();
      if (e.start_seen) begin
         n.rx_cnt = 4'h0;
      end
      if (e.scl_fall) begin
         n.revert_cnt = 8'h00;
      end else if (e.vclk_rise) begin
         if (s.revert_cnt == `STREAM_REVERT_PULSES - 8'h01) begin
            // Restart the stream from location zero, top bit first.
            n.ptr = `STREAM_START_ADDR;
            n = start_stream(n, b0);
         end else begin
            n.revert_cnt = s.revert_cnt + 8'h01;
         end
      end
      if (e.scl_rise && s.rx_cnt <= `STREAM_CTRL_LAST && !e.start_seen) begin
         n.rx_shift = {s.rx_shift[6:0], e.sda_in};
         n.rx_cnt = s.rx_cnt + 4'h1;
         if (s.rx_cnt == `STREAM_CTRL_LAST && ctrl_match(s.rx_shift[6:0])) begin
            n.mode = streamer_pkg::MODE_BIDIR;
            n.sda = released();
         end
      end
      return n;
   endfunction

   // ----------------------------------------
   // Bidirectional mode
   // ----------------------------------------
   // Only a power cycle, seen here as reset, leaves this mode.
   function automatic state_t step_bidir(input state_t s);
      state_t n;
      n = s;
      n.sda = released();
      return n;
   endfunction

   // ----------------------------------------
   // Mode register
   // ----------------------------------------
   always_comb begin
      s_d = s_q;
      case (s_q.mode)
         streamer_pkg::MODE_SYNC: begin
            s_d = step_sync(s_q, ev, cur_byte);
         end
         streamer_pkg::MODE_STREAM: begin
            s_d = step_stream(s_q, ev, cur_byte);
         end
         streamer_pkg::MODE_TRANSIT: begin
            s_d = step_transit(s_q, ev, first_byte);
         end
         streamer_pkg::MODE_BIDIR: begin
            s_d = step_bidir(s_q);
         end
         default: begin
            s_d.mode = streamer_pkg::MODE_SYNC;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         s_q <= '{mode: streamer_pkg::MODE_SYNC, sync_cnt: 4'h0, bit_cnt: 4'h0,
                  ptr: `STREAM_START_ADDR, revert_cnt: 8'h00, rx_cnt: 4'h0,
                  rx_shift: 8'h00, sda: 2'b00};
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign o_sda_out = !s_q.sda.drive_low;
   assign o_sda_oe = s_q.sda.oe;
   assign o_mode = s_q.mode;
   assign o_bidir = (s_q.mode == streamer_pkg::MODE_BIDIR);
   // Writes in two-wire mode need the transmit clock pin high.
   assign o_write_enable = o_bidir && vclk_level;
endmodule // dual_mode_transmit_only_streamer
`default_nettype wire

// *** streamer_map.svh ***
// Constants for the dual mode transmit-only streamer.
`ifndef STREAMER_MAP_SVH
`define STREAMER_MAP_SVH
`define STREAM_START_ADDR 7'h00
`define STREAM_LAST_ADDR 7'h7F
`define STREAM_SYNC_CLOCKS 4'h9
`define STREAM_SLOT_BITS 4'h9
`define STREAM_NULL_SLOT 4'h8
`define STREAM_REVERT_PULSES 8'h80
`define STREAM_CTRL_CODE 7'h50
`define STREAM_CTRL_LAST 4'h7
`define STREAM_SDA_IDLE 1'h1
`endif

// *** streamer_pkg.sv ***
// Types shared by the streamer files.
`default_nettype none
package streamer_pkg;
   typedef enum logic [1:0] {
      MODE_SYNC = 2'b00,
      MODE_STREAM = 2'b01,
      MODE_TRANSIT = 2'b10,
      MODE_BIDIR = 2'b11
   } mode_t;

   typedef struct packed {
      logic vclk_rise;
      logic scl_fall;
      logic scl_rise;
      logic sda_in;
      logic start_seen;
   } pin_events_t;

   typedef struct packed {
      logic drive_low;
      logic oe;
   } sda_drive_t;
endpackage
`default_nettype wire

// *** pin_sync.sv ***
// Two-stage synchroniser with edge and start detection for the serial pins.
`default_nettype none
module pin_sync (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_vclk,
   input wire logic i_scl,
   input wire logic i_sda,
   output var streamer_pkg::pin_events_t o_events,
   output logic o_vclk_level
);
   typedef struct packed {
      logic [2:0] meta;
      logic [2:0] sync;
      logic [2:0] prev;
   } sync_state_t;

   sync_state_t s_q;
   sync_state_t s_d;

   // ----------------------------------------
   // Synchronise and detect edges
   // ----------------------------------------
   // Only the second and third stages are examined; the first stage may be metastable.
   always_comb begin
      s_d = s_q;
      s_d.meta = {i_vclk, i_scl, i_sda};
      s_d.sync = s_q.meta;
      s_d.prev = s_q.sync;
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         s_q <= '{meta: 3'h7, sync: 3'h7, prev: 3'h7};
      end else begin
         s_q <= s_d;
      end
   end

   always_comb begin
      o_events.vclk_rise = s_q.sync[2] && !s_q.prev[2];
      o_events.scl_fall = !s_q.sync[1] && s_q.prev[1];
      o_events.scl_rise = s_q.sync[1] && !s_q.prev[1];
      o_events.sda_in = s_q.sync[0];
      o_events.start_seen = s_q.sync[1] && s_q.prev[1] && !s_q.sync[0] && s_q.prev[0];
      o_vclk_level = s_q.sync[2];
   end
endmodule // pin_sync
`default_nettype wire

// *** stream_props.sv ***
// Port checks for the dual mode streamer.
`default_nettype none
module stream_props (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_vclk,
   input wire logic o_sda_out,
   input wire logic o_sda_oe,
   input wire logic [1:0] o_mode,
   input wire logic o_bidir,
   input wire logic o_write_enable
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_resetn);
   pull_low_a: assert property (o_sda_oe |-> !o_sda_out) else $error("high");
   sync_quiet_a: assert property (o_mode == 2'h0 |-> !o_sda_oe) else $error("sync");
   transit_quiet_a: assert property (o_mode == 2'h2 |-> !o_sda_oe) else $error("transit");
   bidir_flag_a: assert property (o_bidir == (o_mode == 2'h3)) else $error("flag");
   bidir_hold_a: assert property (o_bidir |=> o_bidir && !o_sda_oe) else $error("left");
   stream_exit_a: assert property (o_mode == 2'h1 |=> o_mode inside {2'h1, 2'h2})
      else $error("exit");
   revert_to_a: assert property (o_mode == 2'h2 |=> o_mode != 2'h0) else $error("revert");
   write_gate_a: assert property ((o_bidir && i_vclk)[*5] |-> o_write_enable)
      else $error("write");
   cover property (o_mode == 2'h2 ##1 o_mode == 2'h1);
   cover property (o_bidir);
   cover property (o_sda_oe);
endmodule // stream_props
bind dual_mode_transmit_only_streamer stream_props chk (
   .i_clk(i_clk),
   .i_resetn(i_resetn),
   .i_vclk(i_vclk),
   .o_sda_out(o_sda_out),
   .o_sda_oe(o_sda_oe),
   .o_mode(o_mode),
   .o_bidir(o_bidir),
   .o_write_enable(o_write_enable)
);
`default_nettype wire

// *** far_host.sv ***
// Host model: transmit clock bursts and a two-wire bus master.
`default_nettype none
module far_host (
   output logic o_vclk,
   output logic o_scl,
   output logic o_sda
);
   timeunit 1ns;
   timeprecision 100ps;
   event bit_ready;
   initial begin
      o_vclk = 1'h0;
      o_scl = 1'h1;
      o_sda = 1'h1;
   end
   // The transmit clock rests low between bursts, as a real host leaves it.
   task automatic vpulse(input int n);
      repeat (n) begin
         o_vclk = 1'h1;
         #40 o_vclk = 1'h0;
         #36 ->bit_ready;
         #4;
      end
   endtask
   task automatic vset(input logic v);
      o_vclk = v;
      #100;
   endtask
   task automatic scl_set(input logic v);
      o_scl = v;
      #200;
   endtask
   task automatic sda_set(input logic v);
      o_sda = v;
      #200;
   endtask
endmodule // far_host
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the dual mode streamer.
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic i_clk;
   logic i_resetn;
   logic i_mem_we;
   logic o_sda_out;
   logic o_sda_oe;
   logic o_bidir;
   logic o_write_enable;
   logic [7:0] rw_byte;
   logic [6:0] i_mem_addr;
   logic [7:0] i_mem_wdata;
   logic [1:0] o_mode;
   logic [7:0] mem [128];
   logic exp_q [$];
   logic [31:0] seed = 32'h18;
   logic [6:0] ctrl = 7'h50;
   int n_mismatch = 0;
   int n_checks = 0;
   wire logic vclk, scl, sda_m;
   wire logic sda_w = sda_m & (o_sda_oe ? o_sda_out : 1'h1);
   far_host far (
      .o_vclk(vclk),
      .o_scl(scl),
      .o_sda(sda_m)
   );
   dual_mode_transmit_only_streamer dut (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_vclk(vclk),
      .i_scl(scl),
      .i_sda(sda_w),
      .i_mem_we(i_mem_we),
      .i_mem_addr(i_mem_addr),
      .i_mem_wdata(i_mem_wdata),
      .o_sda_out(o_sda_out),
      .o_sda_oe(o_sda_oe),
      .o_mode(o_mode),
      .o_bidir(o_bidir),
      .o_write_enable(o_write_enable)
   );
   initial begin
      i_clk = 1'h0;
      forever #5 i_clk = ~i_clk;
   end
   function automatic logic [7:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic push_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         exp_q.push_back(b[i]);
      end
      exp_q.push_back(1'h1);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      forever begin
         @(far.bit_ready);
         if (exp_q.size() == 0) begin
            check("sda_note", 8'h01, 8'h00);
         end else begin
            check("sda", {7'h0, sda_w}, {7'h0, exp_q.pop_front()});
         end
      end
   end
   initial begin
      #400000;
      n_mismatch++;
      final_report();
   end
   initial begin
      i_resetn = 1'h0;
      i_mem_we = 1'h0;
      i_mem_addr = 7'h00;
      i_mem_wdata = 8'h00;
      repeat (4) @(posedge i_clk);
      #1 i_resetn = 1'h1;
      check("mode", {6'h0, o_mode}, 8'h00);
      for (int a = 0; a < 128; a++) begin
         mem[a] = xs();
         i_mem_we = 1'h1;
         i_mem_addr = 7'(a);
         i_mem_wdata = mem[a];
         @(posedge i_clk);
         #1;
      end
      i_mem_we = 1'h0;
      repeat (9) exp_q.push_back(1'h1);
      for (int k = 0; k <= 128; k++) push_byte(mem[k % 128]);
      far.vpulse(9 + 129 * 9);
      check("mode", {6'h0, o_mode}, 8'h01);
      $display("stream test done");
      far.scl_set(1'h0);
      check("mode", {6'h0, o_mode}, 8'h02);
      repeat (227) exp_q.push_back(1'h1);
      push_byte(mem[0]);
      far.vpulse(100);
      far.scl_set(1'h1);
      far.scl_set(1'h0);
      far.vpulse(136);
      check("mode", {6'h0, o_mode}, 8'h01);
      $display("revert test done");
      far.scl_set(1'h0);
      far.scl_set(1'h1);
      far.sda_set(1'h0);
      for (int i = 6; i >= 0; i--) begin
         far.scl_set(1'h0);
         far.sda_set(ctrl[i]);
         far.scl_set(1'h1);
      end
      check("mode", {6'h0, o_mode}, 8'h02);
      rw_byte = xs();
      far.scl_set(1'h0);
      far.sda_set(rw_byte[0]);
      far.scl_set(1'h1);
      check("mode", {6'h0, o_mode}, 8'h03);
      far.scl_set(1'h0);
      far.sda_set(1'h1);
      far.scl_set(1'h1);
      repeat (18) exp_q.push_back(1'h1);
      far.vpulse(18);
      far.vset(1'h1);
      check("write", {7'h0, o_write_enable}, 8'h01);
      far.vset(1'h0);
      check("write", {7'h0, o_write_enable}, 8'h00);
      check("mode", {6'h0, o_mode}, 8'h03);
      $display("bidir test done");
      @(posedge i_clk);
      #1 i_resetn = 1'h0;
      repeat (4) @(posedge i_clk);
      #1 i_resetn = 1'h1;
      check("bidir", {7'h0, o_bidir}, 8'h00);
      check("mode", {6'h0, o_mode}, 8'h00);
      check("queue", 8'(exp_q.size()), 8'h00);
      $display("reset test done");
      final_report();
   end
endmodule // tb_top
`default_nettype wire
